/* core/scte_pkg.sv */
// Shared constants and types of the split capture timer
package scte_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_MODE_EXT  = 8'h93;
  localparam logic [7:0] ADDR_CONTROL   = 8'hC8;
  localparam logic [7:0] ADDR_MODE      = 8'hC9;
  localparam logic [7:0] ADDR_RELOAD_LO = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_HI = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LO  = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HI  = 8'hCD;

  localparam logic [7:0]  REG_RESET = 8'h00;
  localparam logic [7:0]  BYTE_MAX  = 8'hFF;
  localparam logic [15:0] WORD_MAX  = 16'hFFFF;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0]  BYTE_ONE  = 8'h01;
  localparam logic [15:0] WORD_ONE  = 16'h0001;

  // Control register fields
  localparam int CTRL_OVF  = 7;
  localparam int CTRL_EXT  = 6;
  localparam int CTRL_LOVF = 5;
  localparam int CTRL_LIE  = 4;
  localparam int CTRL_FEE  = 3;
  localparam int CTRL_RUN  = 2;
  localparam int CTRL_CT   = 1;
  localparam int CTRL_CPRL = 0;

  // Mode register fields
  localparam int MODE_SPL  = 7;
  localparam int MODE_B6   = 6;
  localparam int MODE_REE  = 5;
  localparam int MODE_X12  = 4;
  localparam int MODE_LRUN = 3;
  localparam int MODE_LAS  = 2;
  localparam int MODE_OE   = 1;
  localparam int MODE_MS0  = 0;

  // Extended mode register fields
  localparam int EXT_LCS   = 7;
  localparam int EXT_IGN   = 6;
  localparam int EXT_AS    = 5;
  localparam int EXT_CKS   = 4;
  localparam int EXT_MS1   = 3;
  localparam int EXT_CPS_H = 2;

  // Operating modes {mode_bit1, capture_reload_bit, mode_bit0}
  localparam logic [2:0] OPM_AR_EXT = 3'h0;
  localparam logic [2:0] OPM_AR     = 3'h1;
  localparam logic [2:0] OPM_CAP    = 3'h2;
  localparam logic [2:0] OPM_CAPZ   = 3'h3;
  localparam logic [2:0] OPM_PWM    = 3'h4;
  localparam logic [2:0] OPM_DUTY   = 3'h6;

  // Prescaler
  localparam logic [3:0] DIV_LAST = 4'hB;
  localparam logic [3:0] DIV_ZERO = 4'h0;
  localparam logic [3:0] DIV_ONE  = 4'h1;

  typedef enum logic [1:0] {
    DUTY_WAIT,
    DUTY_HIGH,
    DUTY_LOW
  } scte_duty_e;

endpackage

/* core/scte_div12.sv */
// System clock divide-by-twelve tick
`timescale 1ns/10ps
module scte_div12 import scte_pkg::*; (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Tick
  output wire logic tick
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } scte_div_s;

  scte_div_s s;
  scte_div_s next_s;

  always_comb begin
    next_s      = s;
    next_s.tick = (s.cnt == DIV_LAST);
    if (s.cnt == DIV_LAST) begin
      next_s.cnt = DIV_ZERO;
    end else begin
      next_s.cnt = s.cnt + DIV_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule

/* core/scte_sync_edge.sv */
// Two-stage synchroniser with edge detect
`timescale 1ns/10ps
module scte_sync_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Input level
  input  wire logic din,
  // Edge pulses
  output wire logic rise,
  output wire logic fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } scte_sync_s;

  scte_sync_s s;
  scte_sync_s next_s;

  always_comb begin
    next_s      = s;
    next_s.meta = din;
    next_s.sync = s.meta;
    next_s.prev = s.sync;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Edges compare the two settled samples only
  assign rise = s.sync & ~s.prev;
  assign fall = ~s.sync & s.prev;

endmodule

/* core/scte_timer.sv */
// Split capture timer: registers, counting, capture and flags
`timescale 1ns/10ps
// Functional notes
// - Overflow sets overflow_flag; only software clears it.
// - Enabled falling or rising trigger edge sets external_flag, in duty mode only the capture and stop edges; software clears.
// - In power-down with interrupt enabled, external_flag is a wake level.
// - Split mode low-byte overflow sets low_overflow_flag; software clears.
// - low_irq_enable gates low_overflow_flag onto the shared interrupt.
// - fall_edge_enable allows capture or reload on falling trigger edge.
// - Mode 0 still reports enabled trigger edges through external_flag.
// - Count only while run_bit set; split mode it governs high byte.
// - Counting clock chosen by {clock_select, x12_select, counter_select}.
// - Mode decoded from {mode_bit1, capture_reload_bit, mode_bit0}.
// - split_enable makes two independent 8-bit timers.
// - Mode bit 6 maps to low_x12 or ext_invert by access select.
// - Split low byte clock chosen by {low_clock_select, low_x12}.
// - ext_invert inverts trigger input before edge detection.
// - rise_edge_enable allows capture or reload and flag on rising edge.
// - Split low byte runs only while low_run_bit set.
// - low_auto_stop clears low_run_bit on high overflow in modes 0 and 1 or on capture.
// - Clock or PWM reaches clock_out_pin only with clock_out_enable.
// - overflow_irq_ignore suppresses overflow_flag interrupt.
// - Capture trigger chosen by a three-bit source selector.
// - Duty mode: wait first rise, capture second edge, stop on third.
// - Capture with auto-zero clears the count on capture; split mode the high byte only.
// - Split PWM: high overflow sets flag and loads compare from buffer.
// - Clock-out toggles output per overflow, in split mode per low-byte overflow, for 50% duty.
module scte_timer import scte_pkg::*; (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output wire logic [7:0] sfr_rdata,
  // Pin and event inputs
  input  wire logic       count_pin,
  input  wire logic       trigger_pin,
  input  wire logic       slave_select_pin,
  input  wire logic       second_twowire_clock,
  input  wire logic       comp0_output,
  input  wire logic       comp2_output,
  input  wire logic       irq2_event,
  input  wire logic       irq3_event,
  input  wire logic       timer0_overflow,
  input  wire logic       comp2_event,
  input  wire logic       comp0_event,
  // Processor state
  input  wire logic       power_down,
  input  wire logic       irq_enable,
  // Outputs
  output wire logic       timer_irq,
  output wire logic       wake_req,
  output wire logic       clock_out_pin
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] mode_ext;
    logic       low_x12;
    logic       ext_invert;
    logic [7:0] reload_low;
    logic [7:0] reload_high;
    logic [7:0] count_low;
    logic [7:0] count_high;
    logic       toggle;
    logic       cko;
    logic [7:0] rdata;
    scte_duty_e duty;
  } scte_state_s;

  scte_state_s s;
  scte_state_s next_s;

  logic       div_tick, cnt_fall, trig_rise, trig_fall, trigger_input;
  logic       split, duty, run, hi_tick, lo_tick, ext_ev;
  logic       hi_step, lo_step, ovf16, hi_ovf, lo_ovf, ovf_any;
  logic       reload_mode, cap_mode, ext_hit, auto_stop;
  logic       duty_cap, duty_stop, duty_flag;
  logic [2:0] opm, hi_clk;
  logic [1:0] lo_clk;
  logic [3:0] lo_src;
  logic [7:0] hi_src, trig_src;

  scte_div12 u_div (
    .clk  (clk),
    .rst_b(rst_b),
    .tick (div_tick)
  );

  scte_sync_edge u_cnt_pin (
    .clk  (clk),
    .rst_b(rst_b),
    .din  (count_pin),
    .rise (),
    .fall (cnt_fall)
  );

  scte_sync_edge u_trig (
    .clk  (clk),
    .rst_b(rst_b),
    .din  (trigger_input),
    .rise (trig_rise),
    .fall (trig_fall)
  );

  assign opm    = {s.mode_ext[EXT_MS1], s.ctrl[CTRL_CPRL], s.mode[MODE_MS0]};
  assign split  = s.mode[MODE_SPL];
  assign duty   = (opm == OPM_DUTY) && !split;
  assign run    = s.ctrl[CTRL_RUN];
  assign hi_clk = {s.mode_ext[EXT_CKS], s.mode[MODE_X12], s.ctrl[CTRL_CT]};
  assign lo_clk = {s.mode_ext[EXT_LCS], s.low_x12};

  // Sources listed by their select code; unused codes never tick
  assign hi_src = {comp0_event, comp2_event, timer0_overflow, 1'b0,
                   split ? lo_ovf : irq2_event, 1'b1, cnt_fall,
                   div_tick};
  assign lo_src = {irq2_event, 1'b0, 1'b1, div_tick};
  assign hi_tick = hi_src[hi_clk];
  assign lo_tick = lo_src[lo_clk];

  // Source switching may show as one spurious edge
  assign trig_src = {second_twowire_clock, comp2_output, comp0_output,
                     1'b0, 1'b0, irq3_event, slave_select_pin,
                     trigger_pin};
  assign trigger_input = trig_src[s.mode_ext[EXT_CPS_H:0]] ^ s.ext_invert;
  assign ext_ev = (trig_fall & s.ctrl[CTRL_FEE])
                | (trig_rise & s.mode[MODE_REE]);

  assign hi_step = run && hi_tick && (!duty || s.duty != DUTY_WAIT);
  assign lo_step = split && opm != OPM_PWM && s.mode[MODE_LRUN]
                && lo_tick;
  assign ovf16   = !split && hi_step && {s.count_high, s.count_low} == WORD_MAX;
  assign hi_ovf  = split && hi_step && s.count_high == BYTE_MAX;
  assign lo_ovf  = lo_step && s.count_low == BYTE_MAX;
  assign ovf_any = ovf16 || hi_ovf;
  assign reload_mode = opm == OPM_AR_EXT || opm == OPM_AR || opm == OPM_PWM;
  assign cap_mode    = opm == OPM_CAP || opm == OPM_CAPZ;
  // Duty capture: first rise starts, falling edge captures, next rise stops
  assign duty_cap  = duty && run && s.duty == DUTY_HIGH && trig_fall;
  assign duty_stop = duty && run && s.duty == DUTY_LOW && trig_rise;
  assign duty_flag = (duty_cap && s.ctrl[CTRL_FEE])
                  || (duty_stop && s.mode[MODE_REE]);
  assign ext_hit   = duty ? duty_flag : ext_ev;
  assign auto_stop = s.mode[MODE_LAS]
                  && ((ovf_any && (opm == OPM_AR_EXT || opm == OPM_AR))
                   || (ext_ev && cap_mode));

  always_comb begin
    logic [15:0] cnt;
    logic [7:0]  wctrl;
    logic        wr_ctrl;
    cnt     = {s.count_high, s.count_low};
    wr_ctrl = sfr_wr && sfr_addr == ADDR_CONTROL;
    wctrl   = wr_ctrl ? sfr_wdata : s.ctrl;
    next_s  = s;

    // Counting
    if (!split) begin
      if (hi_step) begin
        cnt = (ovf16 && reload_mode) ? {s.reload_high, s.reload_low}
                                     : cnt + WORD_ONE;
      end
      if (opm == OPM_AR && ext_ev) begin
        cnt = {s.reload_high, s.reload_low};
      end
      if ((cap_mode && ext_ev) || duty_cap) begin
        next_s.reload_high = s.count_high;
        next_s.reload_low  = s.count_low;
        if (opm == OPM_CAPZ) begin
          cnt = WORD_ZERO;
        end
      end
    end else begin
      if (hi_step) begin
        cnt[15:8] = (hi_ovf && reload_mode) ? s.reload_high
                                            : s.count_high + BYTE_ONE;
      end
      if (lo_step) begin
        cnt[7:0] = lo_ovf ? s.reload_low : s.count_low + BYTE_ONE;
      end
      if (hi_ovf && opm == OPM_PWM) begin
        cnt[7:0] = s.reload_low;
      end
      if (opm == OPM_AR && ext_ev) begin
        cnt[15:8] = s.reload_high;
      end
      if (cap_mode && ext_ev) begin
        next_s.reload_high = s.count_high;
        if (opm == OPM_CAPZ) begin
          cnt[15:8] = WORD_ZERO[15:8];
        end
      end
    end
    next_s.count_high = cnt[15:8];
    next_s.count_low  = cnt[7:0];

    // Duty capture sequence
    if (!duty || !run) begin
      next_s.duty = DUTY_WAIT;
    end else begin
      case (s.duty)
        DUTY_WAIT: if (trig_rise) next_s.duty = DUTY_HIGH;
        DUTY_HIGH: if (trig_fall) next_s.duty = DUTY_LOW;
        DUTY_LOW:  if (trig_rise) next_s.duty = DUTY_WAIT;
        default:   next_s.duty = DUTY_WAIT;
      endcase
    end

    // Clock-out toggles once per overflow; in split mode once per low-byte overflow
    if ((!split && ovf16) || (split && lo_ovf)) begin
      next_s.toggle = ~s.toggle;
    end

    // Register writes; data registers override the count
    if (sfr_wr) begin
      case (sfr_addr)
        ADDR_MODE_EXT:  next_s.mode_ext    = sfr_wdata;
        ADDR_MODE: begin
          next_s.mode = sfr_wdata;
          if (s.mode_ext[EXT_AS]) begin
            next_s.ext_invert = sfr_wdata[MODE_B6];
          end else begin
            next_s.low_x12 = sfr_wdata[MODE_B6];
          end
        end
        ADDR_RELOAD_LO: next_s.reload_low  = sfr_wdata;
        ADDR_RELOAD_HI: next_s.reload_high = sfr_wdata;
        ADDR_COUNT_LO:  next_s.count_low   = sfr_wdata;
        ADDR_COUNT_HI:  next_s.count_high  = sfr_wdata;
        default: begin
        end
      endcase
    end

    // Flags: a hardware set wins over a software clear
    next_s.ctrl            = wctrl;
    next_s.ctrl[CTRL_OVF]  = wctrl[CTRL_OVF] | ovf_any;
    next_s.ctrl[CTRL_EXT]  = wctrl[CTRL_EXT] | ext_hit;
    next_s.ctrl[CTRL_LOVF] = wctrl[CTRL_LOVF] | lo_ovf;
    if (duty_stop) begin
      next_s.ctrl[CTRL_RUN] = 1'b0;
    end
    if (auto_stop) begin
      next_s.mode[MODE_LRUN] = 1'b0;
    end

    // PWM is high while the period count is below the compare byte
    if (!next_s.mode[MODE_OE]) begin
      next_s.cko = 1'b0;
    end else if (split && opm == OPM_PWM) begin
      next_s.cko = next_s.count_high < next_s.count_low;
    end else begin
      next_s.cko = next_s.toggle;
    end

    // Read data is registered; unmapped reads return zero
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_MODE_EXT:  next_s.rdata = s.mode_ext;
        ADDR_CONTROL:   next_s.rdata = s.ctrl;
        ADDR_MODE:      next_s.rdata = {s.mode[MODE_SPL],
                          s.mode_ext[EXT_AS] ? s.ext_invert : s.low_x12,
                          s.mode[MODE_REE:0]};
        ADDR_RELOAD_LO: next_s.rdata = s.reload_low;
        ADDR_RELOAD_HI: next_s.rdata = s.reload_high;
        ADDR_COUNT_LO:  next_s.rdata = s.count_low;
        ADDR_COUNT_HI:  next_s.rdata = s.count_high;
        default:        next_s.rdata = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sfr_rdata     = s.rdata;
  assign clock_out_pin = s.cko;
  assign timer_irq     = (s.ctrl[CTRL_OVF] & ~s.mode_ext[EXT_IGN])
                       | s.ctrl[CTRL_EXT]
                       | (s.ctrl[CTRL_LOVF] & s.ctrl[CTRL_LIE]);
  assign wake_req      = power_down & irq_enable & s.ctrl[CTRL_EXT];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_ovf_sets_flag: assert property (ovf_any |=> s.ctrl[CTRL_OVF])
    else $error("overflow did not set overflow flag");
  a_ovf_flag_hold: assert property (s.ctrl[CTRL_OVF] && !sfr_wr
    |=> s.ctrl[CTRL_OVF])
    else $error("overflow flag cleared without a write");
  a_ext_flag_set: assert property (ext_hit |=> s.ctrl[CTRL_EXT])
    else $error("trigger edge did not set external flag");
  a_wake_level: assert property (power_down && irq_enable
    && s.ctrl[CTRL_EXT] |-> wake_req)
    else $error("wake request missing");
  a_low_ovf_flag: assert property (lo_ovf |=> s.ctrl[CTRL_LOVF])
    else $error("low overflow did not set low flag");
  a_low_irq_gate: assert property (s.ctrl[CTRL_LOVF] && s.ctrl[CTRL_LIE]
    |-> timer_irq)
    else $error("enabled low flag gave no interrupt");
  a_fall_ignored: assert property (trig_fall && !trig_rise
    && !s.ctrl[CTRL_FEE] && !duty && !s.ctrl[CTRL_EXT] && !sfr_wr
    |=> !s.ctrl[CTRL_EXT])
    else $error("disabled falling edge set external flag");
  a_run_halts: assert property (!run && !split && !ext_ev && !sfr_wr
    |=> $stable({s.count_high, s.count_low}))
    else $error("count moved while stopped");
  a_capz_zero: assert property (!split && opm == OPM_CAPZ && ext_ev
    && !sfr_wr |=> {s.count_high, s.count_low} == WORD_ZERO)
    else $error("auto-zero capture left a count");
  a_duty_stop: assert property (duty_stop && !sfr_wr
    |=> !s.ctrl[CTRL_RUN] ##1 s.duty == DUTY_WAIT)
    else $error("third duty edge did not stop");
  a_pwm_load: assert property (hi_ovf && opm == OPM_PWM && !sfr_wr
    |=> s.count_low == $past(s.reload_low))
    else $error("PWM compare not loaded");
  a_auto_stop: assert property (auto_stop && !sfr_wr
    |=> !s.mode[MODE_LRUN])
    else $error("low run bit not cleared");
  a_cko_gated: assert property (!s.mode[MODE_OE] |-> !clock_out_pin)
    else $error("clock out driven while disabled");

  c_ovf16: cover property (ovf16);
  c_split_low: cover property (lo_ovf ##[1:300] hi_ovf);
  c_duty_done: cover property (duty_cap ##[1:1000] duty_stop);
  c_capture: cover property (cap_mode && ext_ev);

endmodule

/* test/scte_src_model.sv */
// Far-side model: trigger pins, count pin and event ticks
`timescale 1ns/10ps
module scte_src_model (
  // Clock
  input  wire logic       clk,
  // Requests from the bench
  input  wire logic [5:0] lvl_req,
  input  wire logic [4:0] pulse_req,
  // Pins and events
  output logic            count_pin,
  output logic [5:0]      lvl,
  output logic [3:0]      tick
);
  logic [2:0] low_cnt = 3'h0;
  // Ticks last one cycle; count pin low long enough for the sync flops
  always @(negedge clk) begin
    lvl  <= lvl_req;
    tick <= pulse_req[3:0];
    low_cnt <= pulse_req[4] ? 3'h4 : low_cnt - 3'(low_cnt != 3'h0);
    count_pin <= !pulse_req[4] && (low_cnt <= 3'h1);
  end
endmodule

/* test/scte_timer_tb_top.sv */
// Self-checking bench of the split capture timer
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
  end
module scte_timer_tb_top import scte_pkg::*; ;
  logic        clk;
  logic        rst_b = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  wire  [7:0]  sfr_rdata;
  logic [5:0]  lvl_req = 6'h00;
  logic [4:0]  pulse_req = 5'h00;
  logic        power_down = 1'b0;
  logic        irq_enable = 1'b0;
  wire         count_pin;
  wire  [5:0]  lvl;
  wire  [3:0]  tick;
  wire         timer_irq;
  wire         wake_req;
  wire         clock_out_pin;
  logic [7:0]  exp_q[$];
  logic [7:0]  exp_b;
  logic        rd_q = 1'b0;
  logic        lv;
  logic [15:0] rnd;
  int          checks = 0;
  int          mismatches = 0;
  int          tg;
  logic [7:0]  regs[7] = '{ADDR_MODE_EXT, ADDR_CONTROL, ADDR_MODE,
    ADDR_RELOAD_LO, ADDR_RELOAD_HI, ADDR_COUNT_LO, ADDR_COUNT_HI};
  logic [2:0]  ck_code[5] = '{3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
  int          ck_line[5] = '{4, 0, 1, 2, 3};
  logic [2:0]  cp_code[6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};

  scte_src_model src (.clk(clk), .lvl_req(lvl_req), .pulse_req(pulse_req),
    .count_pin(count_pin), .lvl(lvl), .tick(tick));

  scte_timer uut (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .count_pin(count_pin), .trigger_pin(lvl[0]),
    .slave_select_pin(lvl[1]), .irq3_event(lvl[2]), .comp0_output(lvl[3]),
    .comp2_output(lvl[4]), .second_twowire_clock(lvl[5]),
    .irq2_event(tick[0]), .timer0_overflow(tick[1]),
    .comp2_event(tick[2]), .comp0_event(tick[3]), .power_down(power_down),
    .irq_enable(irq_enable), .timer_irq(timer_irq), .wake_req(wake_req),
    .clock_out_pin(clock_out_pin));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Read data shows one edge after the read strobe is taken
  always @(posedge clk) begin
    if (rd_q === 1'b1) begin
      exp_b = exp_q.pop_front();
      `CHK(sfr_rdata, exp_b)
    end
    rd_q <= sfr_rd;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(negedge clk);
    sfr_wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    exp_q.push_back(e);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(negedge clk);
    sfr_rd   <= 1'b0;
    @(negedge clk);
  endtask

  task automatic pulse(input logic [4:0] m);
    @(negedge clk);
    pulse_req <= m;
    @(negedge clk);
    pulse_req <= 5'h00;
    idle(8);
  endtask

  task automatic set_lvl(input logic [5:0] v);
    @(negedge clk);
    lvl_req <= v;
    idle(8);
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Whole run is about a thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    conclude();
  end

  initial begin
    void'($urandom(339));
    idle(12);
    rst_b <= 1'b1;
    foreach (regs[i]) rd_reg(regs[i], REG_RESET);
    wr_reg(8'h94, BYTE_MAX);
    rd_reg(8'h94, REG_RESET);
    rnd = 16'($urandom);
    wr_reg(ADDR_COUNT_LO, rnd[7:0]);
    wr_reg(ADDR_COUNT_HI, rnd[15:8]);
    wr_reg(ADDR_RELOAD_HI, ~rnd[15:8]);
    idle(20);
    rd_reg(ADDR_COUNT_LO, rnd[7:0]);
    rd_reg(ADDR_RELOAD_HI, ~rnd[15:8]);
    $display("done: registers");
    // Overflow with reload in mode 1 on the system clock
    wr_reg(ADDR_RELOAD_HI, 8'h12);
    wr_reg(ADDR_COUNT_HI, BYTE_MAX);
    wr_reg(ADDR_COUNT_LO, 8'hFD);
    wr_reg(ADDR_MODE, 8'h11);
    wr_reg(ADDR_CONTROL, 8'h04);
    idle(8);
    wr_reg(ADDR_CONTROL, 8'h80);
    rd_reg(ADDR_CONTROL, 8'h80);
    rd_reg(ADDR_COUNT_HI, 8'h12);
    `CHK(timer_irq, 1'b1)
    wr_reg(ADDR_MODE_EXT, 8'h40);
    `CHK(timer_irq, 1'b0)
    wr_reg(ADDR_MODE_EXT, 8'h00);
    wr_reg(ADDR_CONTROL, 8'h00);
    rd_reg(ADDR_CONTROL, 8'h00);
    $display("done: overflow");
    // Every external count source, with foreign pulses that must not count
    for (int i = 0; i < 5; i++) begin
      wr_reg(ADDR_COUNT_LO, 8'h00);
      wr_reg(ADDR_MODE_EXT, {3'h0, ck_code[i][2], 4'h0});
      wr_reg(ADDR_MODE, {3'h0, ck_code[i][1], 4'h0});
      wr_reg(ADDR_CONTROL, {6'h01, ck_code[i][0], 1'b0});
      repeat (3) pulse(5'(5'h01 << ck_line[i]));
      pulse(~5'(5'h01 << ck_line[i]));
      wr_reg(ADDR_CONTROL, 8'h00);
      rd_reg(ADDR_COUNT_LO, 8'h03);
    end
    $display("done: clock sources");
    // Captures and edge enables with the counter held still
    wr_reg(ADDR_MODE_EXT, 8'h00);
    wr_reg(ADDR_MODE, 8'h00);
    wr_reg(ADDR_COUNT_LO, rnd[7:0]);
    wr_reg(ADDR_COUNT_HI, rnd[15:8]);
    wr_reg(ADDR_CONTROL, 8'h09);
    set_lvl(6'h01);
    rd_reg(ADDR_CONTROL, 8'h09);
    set_lvl(6'h00);
    rd_reg(ADDR_CONTROL, 8'h49);
    rd_reg(ADDR_RELOAD_LO, rnd[7:0]);
    rd_reg(ADDR_RELOAD_HI, rnd[15:8]);
    power_down <= 1'b1;
    irq_enable <= 1'b1;
    idle(1);
    `CHK(wake_req, 1'b1)
    irq_enable <= 1'b0;
    idle(1);
    `CHK(wake_req, 1'b0)
    wr_reg(ADDR_CONTROL, 8'h01);
    set_lvl(6'h01);
    set_lvl(6'h00);
    rd_reg(ADDR_CONTROL, 8'h01);
    wr_reg(ADDR_MODE, 8'h21);
    set_lvl(6'h01);
    rd_reg(ADDR_CONTROL, 8'h41);
    rd_reg(ADDR_COUNT_LO, 8'h00);
    rd_reg(ADDR_COUNT_HI, 8'h00);
    wr_reg(ADDR_MODE_EXT, 8'h20);
    wr_reg(ADDR_MODE, 8'h61);
    wr_reg(ADDR_CONTROL, 8'h01);
    set_lvl(6'h00);
    rd_reg(ADDR_CONTROL, 8'h41);
    rd_reg(ADDR_MODE, 8'h61);
    // Mode 0 reports the edge but leaves the count alone; clear the
    // inversion first, while mode bit 6 still reaches it
    wr_reg(ADDR_MODE, 8'h00);
    wr_reg(ADDR_MODE_EXT, 8'h00);
    wr_reg(ADDR_COUNT_LO, 8'h5A);
    wr_reg(ADDR_CONTROL, 8'h08);
    set_lvl(6'h01);
    set_lvl(6'h00);
    rd_reg(ADDR_CONTROL, 8'h48);
    rd_reg(ADDR_COUNT_LO, 8'h5A);
    $display("done: capture");
    // Each capture source raised once on a rising edge
    wr_reg(ADDR_MODE, 8'h20);
    for (int i = 0; i < 6; i++) begin
      wr_reg(ADDR_CONTROL, 8'h01);
      wr_reg(ADDR_MODE_EXT, {5'h00, cp_code[i]});
      set_lvl(6'(6'h01 << i));
      rd_reg(ADDR_CONTROL, 8'h41);
      set_lvl(6'h00);
    end
    $display("done: capture sources");
    // Duty capture: trigger edges nine cycles apart on the system clock
    wr_reg(ADDR_MODE_EXT, 8'h08);
    wr_reg(ADDR_MODE, 8'h30);
    wr_reg(ADDR_COUNT_LO, 8'h00);
    wr_reg(ADDR_COUNT_HI, 8'h00);
    wr_reg(ADDR_CONTROL, 8'h0D);
    set_lvl(6'h01);
    set_lvl(6'h00);
    set_lvl(6'h01);
    rd_reg(ADDR_CONTROL, 8'h49);
    rd_reg(ADDR_RELOAD_LO, 8'h08);
    rd_reg(ADDR_COUNT_LO, 8'h12);
    $display("done: duty");
    // Split: low byte alone on the system clock
    wr_reg(ADDR_MODE_EXT, 8'h00);
    wr_reg(ADDR_CONTROL, 8'h00);
    wr_reg(ADDR_COUNT_HI, 8'h55);
    wr_reg(ADDR_COUNT_LO, 8'hF8);
    wr_reg(ADDR_MODE, 8'hC8);
    idle(16);
    wr_reg(ADDR_MODE, 8'h80);
    rd_reg(ADDR_CONTROL, 8'h20);
    rd_reg(ADDR_COUNT_HI, 8'h55);
    `CHK(timer_irq, 1'b0)
    wr_reg(ADDR_CONTROL, 8'h30);
    `CHK(timer_irq, 1'b1)
    // High byte overflow stops the low byte
    wr_reg(ADDR_CONTROL, 8'h00);
    wr_reg(ADDR_COUNT_HI, 8'hF0);
    wr_reg(ADDR_MODE, 8'h9C);
    wr_reg(ADDR_CONTROL, 8'h04);
    idle(40);
    wr_reg(ADDR_CONTROL, 8'h80);
    rd_reg(ADDR_MODE, 8'h94);
    rd_reg(ADDR_CONTROL, 8'h80);
    $display("done: split");
    // Clock out: overflow every four ticks
    wr_reg(ADDR_CONTROL, 8'h00);
    wr_reg(ADDR_RELOAD_HI, BYTE_MAX);
    wr_reg(ADDR_RELOAD_LO, 8'hFC);
    wr_reg(ADDR_COUNT_HI, BYTE_MAX);
    wr_reg(ADDR_COUNT_LO, 8'hFC);
    wr_reg(ADDR_MODE, 8'h12);
    wr_reg(ADDR_CONTROL, 8'h04);
    idle(4);
    tg = 0;
    repeat (64) begin
      lv = clock_out_pin;
      @(negedge clk);
      if (clock_out_pin !== lv) tg++;
    end
    `CHK(tg >= 15 && tg <= 17, 1'b1)
    wr_reg(ADDR_MODE, 8'h10);
    idle(3);
    tg = 0;
    repeat (16) begin
      @(negedge clk);
      if (clock_out_pin !== 1'b0) tg++;
    end
    `CHK(tg == 0, 1'b1)
    $display("done: clock out");
    // Split PWM: sixteen-cycle period, high while below compare byte
    wr_reg(ADDR_CONTROL, 8'h00);
    wr_reg(ADDR_MODE_EXT, 8'h08);
    wr_reg(ADDR_RELOAD_HI, 8'hF0);
    wr_reg(ADDR_RELOAD_LO, 8'hF4);
    wr_reg(ADDR_COUNT_HI, 8'hF0);
    wr_reg(ADDR_COUNT_LO, 8'h00);
    wr_reg(ADDR_MODE, 8'h92);
    wr_reg(ADDR_CONTROL, 8'h04);
    idle(40);
    rd_reg(ADDR_CONTROL, 8'h84);
    rd_reg(ADDR_COUNT_LO, 8'hF4);
    tg = 0;
    repeat (64) begin
      @(negedge clk);
      if (clock_out_pin === 1'b1) tg++;
    end
    `CHK(tg, 16)
    $display("done: pwm");
    conclude();
  end
endmodule
